// File: design/rps_top.sv
`timescale 1ns/1ns
// How it works
// - two-bit framing error output per lane, 0..19
// - valid strobe qualifies each lane's error value
// - local fault high if internal or received fault
// - synced bit needs word lock plus lane marker
// - error value counts sync header errors that cycle
module rps_top #(
  parameter int NL = rps_pkg::RPS_LANES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input rps_pkg::rps_lane_in_t [NL-1:0] lane_in,
  input wire logic int_local_fault,
  input wire logic rcv_local_fault,
  input rps_pkg::rps_bus_req_t bus_req,
  output logic [rps_pkg::RPS_DW-1:0] rdata,
  output logic irq,
  output logic [NL-1:0][rps_pkg::RPS_CNT_W-1:0] framing_err,
  output logic [NL-1:0] framing_err_vld,
  output logic local_fault,
  output logic [NL-1:0] synced
);
  import rps_pkg::*;

  logic [RPS_EV_W-1:0] status_r;
  logic [RPS_EV_W-1:0] mask_r;
  logic [RPS_EV_W-1:0] ev;
  logic [RPS_DW-1:0] rdata_r;
  logic irq_r;
  logic local_fault_r;
  logic lf_prev_r;
  logic [NL-1:0] synced_prev_r;
  logic [NL-1:0] err_hit;
  logic [NL-1:0] in_vld;
  logic [NL-1:0] in_lm;
  logic [NL-1:0] in_lock;
  logic rd_status;

  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++) begin : g_lane
      rps_lane u_lane (
        .sys_clk(sys_clk),
        .reset(reset),
        .lane_in(lane_in[gi]),
        .err_cnt_r(framing_err[gi]),
        .err_vld_r(framing_err_vld[gi]),
        .synced_r(synced[gi])
      );
      assign err_hit[gi] = framing_err_vld[gi] && (framing_err[gi] != RPS_CNT_RST);
      assign in_vld[gi] = lane_in[gi].hdr_vld;
      assign in_lock[gi] = lane_in[gi].word_lock;
      assign in_lm[gi] = lane_in[gi].word_lock & lane_in[gi].marker;
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      local_fault_r <= 1'b0;
    end else begin
      local_fault_r <= int_local_fault | rcv_local_fault;
    end
  end
  assign local_fault = local_fault_r;

  // history for edge-type events
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lf_prev_r <= 1'b0;
      synced_prev_r <= '0;
    end else begin
      lf_prev_r <= local_fault_r;
      synced_prev_r <= synced;
    end
  end

  always_comb begin
    ev = RPS_STATUS_RST;
    ev[RPS_EV_FRAMING] = |err_hit;
    ev[RPS_EV_LFAULT] = local_fault_r & ~lf_prev_r;
    ev[RPS_EV_SYNCLOSS] = |(synced_prev_r & ~synced);
  end

  assign rd_status = bus_req.rd && (bus_req.addr == RPS_OFF_STATUS);

  // sticky status; a read clears it but a same-cycle event still lands
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      status_r <= RPS_STATUS_RST;
    end else begin
      status_r <= (rd_status ? RPS_STATUS_RST : status_r) | ev;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mask_r <= RPS_MASK_RST;
    end else if (bus_req.wr && (bus_req.addr == RPS_OFF_MASK)) begin
      mask_r <= bus_req.wdata[RPS_EV_W-1:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= RPS_RDATA_RST;
    end else if (!bus_req.rd) begin
      rdata_r <= RPS_RDATA_RST;
    end else begin
      unique case (bus_req.addr)
        RPS_OFF_STATUS: rdata_r <= RPS_DW'(status_r);
        RPS_OFF_MASK: rdata_r <= RPS_DW'(mask_r);
        RPS_OFF_SYNCED: rdata_r <= RPS_DW'(synced);
        default: rdata_r <= RPS_RDATA_RST;
      endcase
    end
  end
  assign rdata = rdata_r;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(((rd_status ? RPS_STATUS_RST : status_r) | ev) & mask_r);
    end
  end
  assign irq = irq_r;

  property p_lfault;
    @(posedge sys_clk) disable iff (reset)
      (int_local_fault || rcv_local_fault) |=> local_fault;
  endproperty
  a_lfault: assert property (p_lfault) else $error("local fault not raised");

  property p_lfault_low;
    @(posedge sys_clk) disable iff (reset)
      (!int_local_fault && !rcv_local_fault) [*2] |=> !local_fault;
  endproperty
  a_lfault_low: assert property (p_lfault_low) else $error("local fault stuck");

  property p_vld;
    @(posedge sys_clk) disable iff (reset)
      ##1 framing_err_vld == $past(in_vld);
  endproperty
  a_vld: assert property (p_vld) else $error("valid strobe mismatch");

  property p_cnt_top;
    @(posedge sys_clk) disable iff (reset)
      lane_in[NL-1].hdr_vld |=> framing_err_vld[NL-1]
        && framing_err[NL-1] == $past(lane_in[NL-1].hdr_err);
  endproperty
  a_cnt_top: assert property (p_cnt_top) else $error("top lane count wrong");

  property p_cnt_idle;
    @(posedge sys_clk) disable iff (reset)
      !lane_in[0].hdr_vld |=> framing_err[0] == RPS_CNT_RST;
  endproperty
  a_cnt_idle: assert property (p_cnt_idle) else $error("count without valid");

  property p_sync_lock;
    @(posedge sys_clk) disable iff (reset)
      ##1 (synced & ~$past(in_lock)) == '0;
  endproperty
  a_sync_lock: assert property (p_sync_lock) else $error("synced without lock");

  property p_sync_marker;
    @(posedge sys_clk) disable iff (reset)
      ##1 (synced & $past(in_lm)) == $past(in_lm);
  endproperty
  a_sync_marker: assert property (p_sync_marker) else $error("synced missing");

  property p_rd_clear;
    @(posedge sys_clk) disable iff (reset)
      (rd_status && ev == RPS_STATUS_RST) |=> status_r == RPS_STATUS_RST
        && rdata == RPS_DW'($past(status_r));
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("status not cleared");

  property p_sync_level;
    @(posedge sys_clk) disable iff (reset)
      ##1 synced == (($past(in_lock) & $past(synced)) | $past(in_lm));
  endproperty
  a_sync_level: assert property (p_sync_level) else $error("synced level wrong");

  // status bits stay set until software reads them
  property p_sticky;
    @(posedge sys_clk) disable iff (reset)
      !rd_status |=> (status_r & $past(status_r)) == $past(status_r);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");

  property p_set_wins;
    @(posedge sys_clk) disable iff (reset)
      ev != RPS_STATUS_RST |=> (status_r & $past(ev)) == $past(ev);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event not recorded");

  property p_irq_level;
    @(posedge sys_clk) disable iff (reset)
      ##1 irq == |(status_r & $past(mask_r));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_mask_wr;
    @(posedge sys_clk) disable iff (reset)
      (bus_req.wr && bus_req.addr == RPS_OFF_MASK)
        |=> mask_r == $past(bus_req.wdata[RPS_EV_W-1:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  property p_rdata_idle;
    @(posedge sys_clk) disable iff (reset)
      !bus_req.rd |=> rdata == RPS_RDATA_RST;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

  property p_rd_synced;
    @(posedge sys_clk) disable iff (reset)
      (bus_req.rd && bus_req.addr == RPS_OFF_SYNCED) |=> rdata == RPS_DW'($past(synced));
  endproperty
  a_rd_synced: assert property (p_rd_synced) else $error("synced read wrong");

  c_err: cover property (@(posedge sys_clk) disable iff (reset) |err_hit);
  c_lf: cover property (@(posedge sys_clk) disable iff (reset) $rose(local_fault));
  c_sync_all: cover property (@(posedge sys_clk) disable iff (reset) &synced);
  c_irq: cover property (@(posedge sys_clk) disable iff (reset) $rose(irq));

endmodule

// File: design/rps_pkg.sv
package rps_pkg;

  localparam int RPS_LANES = 20;
  localparam int RPS_CNT_W = 2;
  localparam int RPS_AW = 4;
  localparam int RPS_DW = 32;
  localparam int RPS_EV_W = 3;

  // byte addresses of the software registers
  localparam logic [RPS_AW-1:0] RPS_OFF_STATUS = 4'h0;
  localparam logic [RPS_AW-1:0] RPS_OFF_MASK = 4'h4;
  localparam logic [RPS_AW-1:0] RPS_OFF_SYNCED = 4'h8;

  // event bit positions in the status and mask registers
  localparam int RPS_EV_FRAMING = 0;
  localparam int RPS_EV_LFAULT = 1;
  localparam int RPS_EV_SYNCLOSS = 2;

  localparam logic [RPS_EV_W-1:0] RPS_STATUS_RST = 3'h0;
  localparam logic [RPS_EV_W-1:0] RPS_MASK_RST = 3'h0;
  localparam logic [RPS_DW-1:0] RPS_RDATA_RST = 32'h0;
  localparam logic [RPS_CNT_W-1:0] RPS_CNT_RST = 2'h0;

  // per-lane indications from the receive path, same clock
  typedef struct packed {
    logic [RPS_CNT_W-1:0] hdr_err;
    logic hdr_vld;
    logic word_lock;
    logic marker;
  } rps_lane_in_t;

  typedef struct packed {
    logic [RPS_AW-1:0] addr;
    logic [RPS_DW-1:0] wdata;
    logic wr;
    logic rd;
  } rps_bus_req_t;

endpackage

// File: design/rps_lane.sv
`timescale 1ns/1ns
module rps_lane (
  input wire logic sys_clk,
  input wire logic reset,
  input rps_pkg::rps_lane_in_t lane_in,
  output logic [rps_pkg::RPS_CNT_W-1:0] err_cnt_r,
  output logic err_vld_r,
  output logic synced_r
);
  import rps_pkg::*;

  logic marker_seen_r;

  // framing error count and its strobe; count forced to zero when not valid
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      err_cnt_r <= RPS_CNT_RST;
      err_vld_r <= 1'b0;
    end else begin
      err_vld_r <= lane_in.hdr_vld;
      err_cnt_r <= lane_in.hdr_vld ? lane_in.hdr_err : RPS_CNT_RST;
    end
  end

  // marker memory lives only while the lane keeps word lock
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      marker_seen_r <= 1'b0;
    end else if (!lane_in.word_lock) begin
      marker_seen_r <= 1'b0;
    end else if (lane_in.marker) begin
      marker_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      synced_r <= 1'b0;
    end else begin
      synced_r <= lane_in.word_lock & (marker_seen_r | lane_in.marker);
    end
  end

endmodule

// File: sim/rps_stats_model.sv
`timescale 1ns/1ns
module rps_stats_model #(
  parameter int NL = 20
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [NL-1:0][1:0] framing_err,
  input wire logic [NL-1:0] framing_err_vld,
  output logic [31:0] total
);
  logic [31:0] inc;
  always_comb begin
    inc = '0;
    for (int i = 0; i < NL; i++) begin
      if (framing_err_vld[i]) inc += 32'(framing_err[i]);
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) total <= '0;
    else total <= total + inc;
  end
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import rps_pkg::*;
  localparam int NL = RPS_LANES;
  typedef struct {
    logic [NL*2-1:0] fe;
    logic [NL-1:0] fv, sy;
    logic lf;
    logic [31:0] d;
    time due;
  } rps_exp_t;
  logic sys_clk = 0, reset = 1, int_local_fault = 0, rcv_local_fault = 0;
  rps_lane_in_t [NL-1:0] lane_in = '0;
  rps_bus_req_t bus_req = '0;
  logic [31:0] rdata, total;
  logic [NL-1:0][1:0] framing_err;
  logic [NL-1:0] framing_err_vld, synced, mem = '0, lk = '0;
  logic irq, local_fault;
  int n_errors = 0, samples_checked = 0, sum = 0;
  logic [RPS_EV_W-1:0] st = '0;
  logic lfp = 1'b0;
  rps_exp_t q[$], rq[$];
  always #10 sys_clk = ~sys_clk;
  rps_top #(.NL(NL)) rps_top_i (.sys_clk, .reset, .lane_in, .int_local_fault,
    .rcv_local_fault, .bus_req, .rdata, .irq, .framing_err, .framing_err_vld,
    .local_fault, .synced);
  rps_stats_model #(.NL(NL)) rps_stats_model_i (.sys_clk, .reset, .framing_err,
    .framing_err_vld, .total);
  task automatic chk(input logic [63:0] s, input logic [63:0] x);
    samples_checked++;
    if (s !== x) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic complete_run();
    $display("checked=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // expectations fall due one cycle after the edge that launched them
  always @(negedge sys_clk) begin
    if (q.size() > 0 && q[0].due < $time) begin
      chk(framing_err, q[0].fe);
      chk(framing_err_vld, q[0].fv);
      chk(local_fault, q[0].lf);
      chk(synced, q[0].sy);
      void'(q.pop_front());
    end
    if (rq.size() > 0 && rq[0].due < $time) begin
      chk(rdata, rq[0].d);
      void'(rq.pop_front());
    end
  end
  task automatic step(input bit r);
    rps_lane_in_t [NL-1:0] v;
    rps_exp_t x;
    logic fi, fr;
    logic [NL-1:0] old;
    @(posedge sys_clk);
    old = mem;
    fi = r && ($urandom % 4 == 0);
    fr = r && ($urandom % 4 == 0);
    if (!r) lk = '0;
    for (int i = 0; i < NL; i++) begin
      if (r && $urandom % 16 == 0) lk[i] = ~lk[i];
      v[i].hdr_err = r ? 2'($urandom) : 2'h0;
      v[i].hdr_vld = r && $urandom % 2;
      v[i].word_lock = lk[i];
      v[i].marker = r && $urandom % 8 == 0;
      x.fe[i*2+:2] = v[i].hdr_vld ? v[i].hdr_err : 2'h0;
      x.fv[i] = v[i].hdr_vld;
      sum += x.fe[i*2+:2];
      // marker memory lasts only while the lock is unbroken
      mem[i] = lk[i] & (mem[i] | v[i].marker);
    end
    x.sy = mem;
    x.lf = fi | fr;
    // events that the sticky status register must have recorded
    if (x.fe != '0) st[RPS_EV_FRAMING] = 1'b1;
    if (x.lf && !lfp) st[RPS_EV_LFAULT] = 1'b1;
    if ((old & ~mem) != '0) st[RPS_EV_SYNCLOSS] = 1'b1;
    lfp = x.lf;
    x.due = $time + 20;
    lane_in <= v;
    int_local_fault <= fi;
    rcv_local_fault <= fr;
    q.push_back(x);
  endtask
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d, input bit c);
    rps_exp_t x;
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    x.d = d;
    x.due = $time + 20;
    if (c) rq.push_back(x);
    @(posedge sys_clk);
    bus_req <= '0;
  endtask
  task automatic hold(input logic [NL-1:0] lock, input logic [NL-1:0] mk);
    rps_lane_in_t [NL-1:0] v;
    @(posedge sys_clk);
    v = '0;
    for (int i = 0; i < NL; i++) begin
      v[i].word_lock = lock[i];
      v[i].marker = mk[i];
    end
    lane_in <= v;
  endtask
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(51137));
    repeat (6) @(posedge sys_clk);
    reset <= 0;
    for (int n = 0; n < 400; n++) step(1);
    repeat (6) step(0);
    chk(total, sum);
    $display("lane test done");
    bus(0, RPS_OFF_STATUS, 32'(st), 1);
    bus(1, RPS_OFF_STATUS, 32'h7, 0);
    bus(0, RPS_OFF_STATUS, 32'h0, 1);
    bus(0, 4'hC, 32'h0, 1);
    @(posedge sys_clk);
    int_local_fault <= 1;
    repeat (3) @(negedge sys_clk);
    chk(local_fault, 1);
    chk(irq, 0);
    bus(1, RPS_OFF_MASK, 32'h2, 0);
    repeat (2) @(negedge sys_clk);
    chk(irq, 1);
    bus(0, RPS_OFF_MASK, 32'h2, 1);
    bus(0, RPS_OFF_STATUS, 32'h2, 1);
    repeat (2) @(negedge sys_clk);
    chk(irq, 0);
    hold('1, 20'hAAAAA);
    hold('1, 20'h0);
    bus(0, RPS_OFF_SYNCED, 32'hAAAAA, 1);
    hold('1, 20'h55555);
    hold('1, 20'h0);
    bus(0, RPS_OFF_SYNCED, 32'hFFFFF, 1);
    hold('0, 20'h0);
    repeat (2) @(posedge sys_clk);
    bus(0, RPS_OFF_STATUS, 32'h4, 1);
    $display("register test done");
    complete_run();
  end
endmodule
